/* sfpb_bridge.sv */
// serial field protocol bridge: upstream register requests to a field port
`include "sfpb_params.svh"
module sfpb_bridge #(
   parameter int QUEUE_DEPTH = 4,
   parameter int QUEUE_AW = 2,
   parameter int TMO_CYCLES = `SFPB_TMO_CYCLES
) (
   // clock and reset
   input wire logic REF_CLK,
   input wire logic RESETN,
   input wire logic CLK_EN,
   // port configuration
   input wire logic [1:0] MODE,
   input wire logic CTRL_LARGE,
   input wire logic [15:0] BAUD_DIV,
   // upstream request
   input wire logic REQ_VALID,
   output logic REQ_READY,
   input wire logic REQ_WRITE,
   input wire logic [`SFPB_ACC_W-1:0] REQ_ACCESSOR,
   input wire logic [7:0] REQ_DROP,
   input wire logic [15:0] REQ_REG,
   input wire logic [15:0] REQ_WDATA,
   // upstream answer
   output logic RSP_VALID,
   output logic [`SFPB_ACC_W-1:0] RSP_ACCESSOR,
   output logic RSP_ERROR,
   output logic [7:0] RSP_CODE,
   output logic [15:0] RSP_RDATA,
   output logic BUSY,
   // field line
   input wire logic RXD,
   output logic TXD
);
   sfpb_pkg::sfpb_st_t s_r, s_nxt;
   sfpb_char_if ch ();
   logic pop, q_empty;
   logic [`SFPB_REQ_W-1:0] q_data;

   // --------
   // request queue and serial engine
   // --------
   sfpb_req_fifo #(
      .W(`SFPB_REQ_W),
      .DEPTH(QUEUE_DEPTH),
      .AW(QUEUE_AW)
   ) u_fifo (
      .clk(REF_CLK),
      .rst_n(RESETN),
      .ce(CLK_EN),
      .wr_valid(REQ_VALID),
      .wr_data({REQ_WRITE, REQ_ACCESSOR, REQ_DROP, REQ_REG, REQ_WDATA}),
      .wr_ready(REQ_READY),
      .rd_pop(pop),
      .rd_data(q_data),
      .rd_empty(q_empty)
   );

   sfpb_uart u_uart (
      .clk(REF_CLK),
      .rst_n(RESETN),
      .ce(CLK_EN),
      .ch(ch.uart),
      .rxd(RXD),
      .txd(TXD)
   );

   assign ch.tx_valid = (s_r.state == sfpb_pkg::S_SEND);
   assign ch.baud_div = s_r.div;
   assign ch.parity_en = s_r.par_en;
   assign ch.two_stop = s_r.two_stop;
   assign pop = (s_r.state == sfpb_pkg::S_IDLE) && !q_empty;

   always_comb begin
      unique case (s_r.idx)
         3'h0: ch.tx_byte = s_r.op;
         3'h1: ch.tx_byte = s_r.drop;
         3'h2: ch.tx_byte = s_r.addr[15:8];
         3'h3: ch.tx_byte = s_r.addr[7:0];
         3'h4: ch.tx_byte = s_r.wdata[15:8];
         3'h5: ch.tx_byte = s_r.wdata[7:0];
         default: ch.tx_byte = s_r.csum;
      endcase
   end

   // --------
   // controller register areas
   // --------
   function automatic sfpb_pkg::sfpb_area_t area_of(input logic [15:0] r);
      if (r < `SFPB_IN_BASE) begin
         area_of = sfpb_pkg::A_NONE;
      end else if (r < `SFPB_OUT_BASE) begin
         area_of = sfpb_pkg::A_IN;
      end else if (r < `SFPB_IR_BASE) begin
         area_of = sfpb_pkg::A_OUT;
      end else if (r < `SFPB_SR_BASE) begin
         area_of = sfpb_pkg::A_IR;
      end else if (r < `SFPB_TIM_BASE) begin
         area_of = sfpb_pkg::A_SR;
      end else if (r < `SFPB_CNT_BASE) begin
         area_of = sfpb_pkg::A_TIM;
      end else if (r < `SFPB_DAT_BASE) begin
         area_of = sfpb_pkg::A_CNT;
      end else if (r < `SFPB_DAT_LIMIT) begin
         area_of = sfpb_pkg::A_DAT;
      end else begin
         area_of = sfpb_pkg::A_NONE;
      end
   endfunction

   function automatic logic [15:0] base_of(input sfpb_pkg::sfpb_area_t a);
      unique case (a)
         sfpb_pkg::A_IN: base_of = `SFPB_IN_BASE;
         sfpb_pkg::A_OUT: base_of = `SFPB_OUT_BASE;
         sfpb_pkg::A_IR: base_of = `SFPB_IR_BASE;
         sfpb_pkg::A_SR: base_of = `SFPB_SR_BASE;
         sfpb_pkg::A_TIM: base_of = `SFPB_TIM_BASE;
         sfpb_pkg::A_CNT: base_of = `SFPB_CNT_BASE;
         sfpb_pkg::A_DAT: base_of = `SFPB_DAT_BASE;
         sfpb_pkg::A_NONE: base_of = 16'h0000;
      endcase
   endfunction

   // the small controller only has the listed resources
   function automatic logic small_ok(input sfpb_pkg::sfpb_area_t a, input logic [15:0] r);
      unique case (a)
         sfpb_pkg::A_IN: small_ok = (r == `SFPB_IN_BASE) || (r == `SFPB_IN_EXP);
         sfpb_pkg::A_OUT: small_ok = (r == `SFPB_OUT_BASE) || (r == `SFPB_OUT_EXP);
         sfpb_pkg::A_IR: small_ok = (r <= `SFPB_IR_SMALL_END);
         sfpb_pkg::A_SR: small_ok = (r <= `SFPB_SR_SMALL_END);
         sfpb_pkg::A_TIM: small_ok = (r <= `SFPB_TIM_SMALL_END);
         sfpb_pkg::A_CNT: small_ok = (r <= `SFPB_CNT_SMALL_END);
         sfpb_pkg::A_DAT: small_ok = 1'b0;
         sfpb_pkg::A_NONE: small_ok = 1'b0;
      endcase
   endfunction

   // --------
   // transaction sequencer
   // --------
   always_comb begin
      logic wr;
      logic [15:0] reg_num;
      sfpb_pkg::sfpb_area_t area;
      logic bad;
      wr = q_data[44];
      reg_num = q_data[31:16];
      area = area_of(reg_num);
      bad = 1'b0;
      s_nxt = s_r;
      s_nxt.rsp_valid = 1'b0;
      unique case (s_r.state)
         sfpb_pkg::S_IDLE: begin
            // field bytes heard here are dropped, never turned upstream
            if (!q_empty) begin
               s_nxt.state = sfpb_pkg::S_LOAD;
               s_nxt.busy = 1'b1;
            end else begin
               s_nxt.busy = 1'b0;
            end
         end
         sfpb_pkg::S_LOAD: begin
            s_nxt.acc = q_data[43:40];
            s_nxt.drop = q_data[39:32];
            s_nxt.wdata = q_data[15:0];
            s_nxt.addr = reg_num;
            s_nxt.bit_area = 1'b0;
            s_nxt.idx = 3'h0;
            s_nxt.csum = 8'h00;
            s_nxt.par_en = 1'b1;
            s_nxt.two_stop = 1'b0;
            s_nxt.div = (BAUD_DIV == 16'h0000) ? 16'(`SFPB_DIV_DEFAULT) : BAUD_DIV;
            unique case (MODE)
               sfpb_pkg::SFPB_MODE_PT: begin
                  s_nxt.mode = sfpb_pkg::SFPB_MODE_PT;
                  s_nxt.op = wr ? `SFPB_OP_PT_WR : `SFPB_OP_PT_RD;
               end
               sfpb_pkg::SFPB_MODE_CONV: begin
                  s_nxt.mode = sfpb_pkg::SFPB_MODE_CONV;
                  s_nxt.op = wr ? `SFPB_OP_CV_WR : `SFPB_OP_CV_RD;
               end
               sfpb_pkg::SFPB_MODE_LADDER: begin
                  s_nxt.mode = sfpb_pkg::SFPB_MODE_LADDER;
                  s_nxt.div = 16'(`SFPB_DIV_DEFAULT);
                  s_nxt.par_en = !CTRL_LARGE;
                  s_nxt.two_stop = CTRL_LARGE;
                  // bit areas: register is a bit address, so groups 8 apart
                  s_nxt.addr = reg_num - base_of(area);
                  s_nxt.bit_area = (area <= sfpb_pkg::A_SR);
                  // timer/counter writes land on the preset, reads see current
                  s_nxt.op = {`SFPB_OP_LADDER, wr, area,
                              wr && (area == sfpb_pkg::A_TIM || area == sfpb_pkg::A_CNT)};
                  if (!CTRL_LARGE && reg_num == `SFPB_OUT_BASE) begin
                     s_nxt.wdata = {8'h00, q_data[7:0] & `SFPB_OUT_MASK};
                  end
                  bad = (q_data[39:32] == 8'h00) || (area == sfpb_pkg::A_NONE)
                        || (!CTRL_LARGE && !small_ok(area, reg_num));
               end
               default: begin
                  s_nxt.mode = sfpb_pkg::SFPB_MODE_PT;
                  s_nxt.op = wr ? `SFPB_OP_PT_WR : `SFPB_OP_PT_RD;
               end
            endcase
            if (bad) begin
               s_nxt.rsp_valid = 1'b1;
               s_nxt.rsp_acc = q_data[43:40];
               s_nxt.rsp_err = 1'b1;
               s_nxt.rsp_code = `SFPB_ERR_RANGE;
               s_nxt.rsp_data = 16'h0000;
               s_nxt.state = sfpb_pkg::S_IDLE;
            end else begin
               s_nxt.state = sfpb_pkg::S_SEND;
            end
         end
         sfpb_pkg::S_SEND: begin
            if (ch.tx_ready) begin
               s_nxt.csum = s_r.csum ^ ch.tx_byte;
               s_nxt.idx = s_r.idx + 3'h1;
               if (s_r.idx == `SFPB_FRAME_LAST) begin
                  s_nxt.idx = 3'h0;
                  s_nxt.tmo = 24'h000000;
                  s_nxt.state = sfpb_pkg::S_WAIT;
               end
            end
         end
         sfpb_pkg::S_WAIT: begin
            s_nxt.tmo = s_r.tmo + 24'h000001;
            if (ch.rx_valid) begin
               if (ch.rx_err || (s_r.idx == 3'h0 && ch.rx_byte != s_r.drop)) begin
                  s_nxt.idx = 3'h0;
               end else begin
                  s_nxt.idx = s_r.idx + 3'h1;
                  if (s_r.idx == 3'h1) begin
                     s_nxt.rstat = ch.rx_byte;
                  end
                  if (s_r.idx == 3'h2) begin
                     s_nxt.rhi = ch.rx_byte;
                  end
               end
            end
            if (ch.rx_valid && !ch.rx_err && s_r.idx == `SFPB_REPLY_LAST) begin
               s_nxt.state = sfpb_pkg::S_IDLE;
               s_nxt.rsp_valid = 1'b1;
               s_nxt.rsp_acc = s_r.acc;
               s_nxt.rsp_data = s_r.bit_area ? {8'h00, ch.rx_byte}
                                             : {s_r.rhi, ch.rx_byte};
               s_nxt.rsp_err = (s_r.mode == sfpb_pkg::SFPB_MODE_CONV)
                               && (s_r.rstat != `SFPB_ACK);
               s_nxt.rsp_code = s_nxt.rsp_err ? `SFPB_ERR_NAK : 8'h00;
            end else if (s_r.tmo == 24'(TMO_CYCLES - 1)) begin
               s_nxt.state = sfpb_pkg::S_IDLE;
               // passthrough and ladder expire without an answer
               if (s_r.mode == sfpb_pkg::SFPB_MODE_CONV) begin
                  s_nxt.rsp_valid = 1'b1;
                  s_nxt.rsp_acc = s_r.acc;
                  s_nxt.rsp_err = 1'b1;
                  s_nxt.rsp_code = `SFPB_ERR_NORESP;
                  s_nxt.rsp_data = 16'h0000;
               end
            end
         end
      endcase
   end

   always_ff @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         s_r <= '{state: sfpb_pkg::S_IDLE, mode: sfpb_pkg::SFPB_MODE_PT,
                  par_en: 1'b1, div: 16'(`SFPB_DIV_DEFAULT), default: '0};
      end else if (CLK_EN) begin
         s_r <= s_nxt;
      end
   end

   assign RSP_VALID = s_r.rsp_valid;
   assign RSP_ACCESSOR = s_r.rsp_acc;
   assign RSP_ERROR = s_r.rsp_err;
   assign RSP_CODE = s_r.rsp_code;
   assign RSP_RDATA = s_r.rsp_data;
   assign BUSY = s_r.busy;
endmodule // sfpb_bridge

/* sfpb_bridge_chk.sv */
// port-level assertions for the serial field protocol bridge
`include "sfpb_params.svh"
module sfpb_bridge_chk (
   // clock and reset
   input wire logic REF_CLK,
   input wire logic RESETN,
   input wire logic CLK_EN,
   // request side
   input wire logic [1:0] MODE,
   input wire logic REQ_VALID,
   input wire logic REQ_READY,
   input wire logic [7:0] REQ_DROP,
   // answer side and field line
   input wire logic RSP_VALID,
   input wire logic [`SFPB_ACC_W-1:0] RSP_ACCESSOR,
   input wire logic RSP_ERROR,
   input wire logic [7:0] RSP_CODE,
   input wire logic [15:0] RSP_RDATA,
   input wire logic BUSY,
   input wire logic TXD
);
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RESETN);
   sequence s_take;
      REQ_VALID && REQ_READY && CLK_EN;
   endsequence
   sequence s_reject;
      RSP_VALID && RSP_ERROR && RSP_CODE == `SFPB_ERR_RANGE;
   endsequence
   chk_reset_vals: assert property (disable iff (1'b0)
      !RESETN |-> REQ_READY && !RSP_VALID && !BUSY && TXD)
      else $error("outputs not at reset values");
   chk_rsp_pulse: assert property (RSP_VALID && CLK_EN |=> !RSP_VALID)
      else $error("answer strobe longer than one cycle");
   chk_rsp_hold: assert property (!RSP_VALID |->
      $stable({RSP_ACCESSOR, RSP_ERROR, RSP_CODE, RSP_RDATA}))
      else $error("answer fields moved without a strobe");
   chk_err_code: assert property (RSP_VALID && RSP_ERROR |->
      RSP_CODE inside {8'h11, 8'h12, 8'h13})
      else $error("error answer with unknown code");
   chk_busy_start: assert property (s_take ##0 !BUSY |-> ##[1:3] BUSY)
      else $error("taken request did not start service");
   chk_tx_start: assert property ($rose(BUSY) && MODE != 2'b10 |-> ##[0:3] !TXD)
      else $error("no start bit after service began");
   chk_ladder_reject: assert property (s_take ##0 (MODE == 2'b10 && REQ_DROP == 8'h00
      && !BUSY) |-> ##[2:4] s_reject)
      else $error("drop zero not refused");
   chk_idle_line: assert property (!BUSY |-> TXD)
      else $error("line not marking while idle");
endmodule // sfpb_bridge_chk

bind sfpb_bridge sfpb_bridge_chk u_chk (.REF_CLK(REF_CLK), .RESETN(RESETN),
   .CLK_EN(CLK_EN), .MODE(MODE), .REQ_VALID(REQ_VALID), .REQ_READY(REQ_READY),
   .REQ_DROP(REQ_DROP), .RSP_VALID(RSP_VALID), .RSP_ACCESSOR(RSP_ACCESSOR),
   .RSP_ERROR(RSP_ERROR), .RSP_CODE(RSP_CODE), .RSP_RDATA(RSP_RDATA), .BUSY(BUSY),
   .TXD(TXD));

/* sfpb_char_if.sv */
// character link between the bridge controller and its serial engine
interface sfpb_char_if;
   logic tx_valid;
   logic tx_ready;
   logic [7:0] tx_byte;
   logic rx_valid;
   logic rx_err;
   logic [7:0] rx_byte;
   logic [15:0] baud_div;
   logic parity_en;
   logic two_stop;
   modport uart (input tx_valid, tx_byte, baud_div, parity_en, two_stop,
                 output tx_ready, rx_valid, rx_byte, rx_err);
   modport ctl (output tx_valid, tx_byte, baud_div, parity_en, two_stop,
                input tx_ready, rx_valid, rx_byte, rx_err);
endinterface

/* sfpb_field_model.sv */
// field unit model: takes a request frame, answers with drop, status and data
module sfpb_field_model (
   input wire logic clk,
   input wire logic txd,
   input wire logic [15:0] div,
   input wire logic par_en,
   input wire logic [15:0] lag,
   input wire logic silent,
   input wire logic [7:0] status,
   input wire logic [15:0] data,
   output logic rxd,
   output logic [55:0] frame,
   output logic par_bad
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] c;
   task automatic get_char(output logic [7:0] ch);
      @(negedge txd);
      repeat (div / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
         repeat (div) @(posedge clk);
         ch[i] = txd;
      end
      repeat (div) @(posedge clk);
      if (par_en && txd !== ^ch) par_bad = 1'b1;
      if (par_en) repeat (div) @(posedge clk);
   endtask
   task automatic put_char(input logic [7:0] ch);
      rxd <= 1'b0;
      repeat (div) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
         rxd <= ch[i];
         repeat (div) @(posedge clk);
      end
      if (par_en) rxd <= ^ch;
      if (par_en) repeat (div) @(posedge clk);
      rxd <= 1'b1;
      repeat (div) @(posedge clk);
   endtask
   initial begin
      rxd = 1'b1;
      par_bad = 1'b0;
      forever begin
         for (int k = 0; k < 7; k++) begin
            get_char(c);
            frame[8*k +: 8] = c;
         end
         repeat (lag) @(posedge clk);
         if (!silent) begin
            put_char(frame[15:8]);
            put_char(status);
            put_char(data[15:8]);
            put_char(data[7:0]);
         end
      end
   end
endmodule // sfpb_field_model

/* sfpb_params.svh */
// constants and timing counts for the serial field protocol bridge
//
// Behaviour
// - final route drop is the field station
// - one field transaction at a time, requests queued
// - convert mode, no answer gives error 17
// - passthrough mode, no answer just times out
// - default 8 data, even parity, 9600 baud
// - convert mode reformats frames, needs acknowledgment
// - ladder mode uses native frames, final drop
// - controller-originated frames are never translated upstream
// - bit areas return eight bits from address
// - bit groups overlap; distinct groups eight apart
// - timers, counters, data are 16-bit words
// - timer/counter read current, write loads preset
// - small controller: 9600, even, 8, 1 stop
// - small controller inputs/outputs at 256/264/384/392
// - small controller relay, shift, timer, counter ranges
// - large controller: 9600, no parity, 8, 2 stop
`ifndef SFPB_PARAMS_SVH
`define SFPB_PARAMS_SVH

// --------
// clock and line timing
// --------
`define SFPB_CLK_HZ 50000000
`define SFPB_BAUD_DEFAULT 9600
`define SFPB_DIV_DEFAULT (`SFPB_CLK_HZ / `SFPB_BAUD_DEFAULT)
`define SFPB_TMO_MS 100
`define SFPB_TMO_CYCLES (`SFPB_CLK_HZ / 1000 * `SFPB_TMO_MS)

// --------
// request layout and frames
// --------
`define SFPB_ACC_W 4
`define SFPB_REQ_W 45
`define SFPB_FRAME_LAST 3'h6
`define SFPB_REPLY_LAST 3'h3
`define SFPB_ACK 8'h06
`define SFPB_OP_PT_RD 8'h01
`define SFPB_OP_PT_WR 8'h02
`define SFPB_OP_CV_RD 8'h03
`define SFPB_OP_CV_WR 8'h04
`define SFPB_OP_LADDER 3'h5
`define SFPB_ERR_NORESP 8'h11
`define SFPB_ERR_NAK 8'h12
`define SFPB_ERR_RANGE 8'h13

// --------
// controller register areas
// --------
`define SFPB_IN_BASE 16'h0100
`define SFPB_IN_EXP 16'h0108
`define SFPB_OUT_BASE 16'h0180
`define SFPB_OUT_EXP 16'h0188
`define SFPB_OUT_MASK 8'h1f
`define SFPB_IR_BASE 16'h0200
`define SFPB_IR_SMALL_END 16'h02f8
`define SFPB_SR_BASE 16'h0300
`define SFPB_SR_SMALL_END 16'h0378
`define SFPB_TIM_BASE 16'h0400
`define SFPB_TIM_SMALL_END 16'h044f
`define SFPB_CNT_BASE 16'h0500
`define SFPB_CNT_SMALL_END 16'h052e
`define SFPB_DAT_BASE 16'h0700
`define SFPB_DAT_LIMIT 16'h0800

`endif

/* sfpb_pkg.sv */
// types shared by the serial field protocol bridge modules
`include "sfpb_params.svh"
package sfpb_pkg;

   typedef enum logic [1:0] {
      SFPB_MODE_PT = 2'b00,
      SFPB_MODE_CONV = 2'b01,
      SFPB_MODE_LADDER = 2'b10
   } sfpb_mode_t;

   typedef enum logic [1:0] {
      S_IDLE = 2'b00,
      S_LOAD = 2'b01,
      S_SEND = 2'b10,
      S_WAIT = 2'b11
   } sfpb_state_t;

   typedef enum logic [2:0] {
      A_IN = 3'b000,
      A_OUT = 3'b001,
      A_IR = 3'b010,
      A_SR = 3'b011,
      A_TIM = 3'b100,
      A_CNT = 3'b101,
      A_DAT = 3'b110,
      A_NONE = 3'b111
   } sfpb_area_t;

   typedef struct packed {
      logic [15:0] tcnt;
      logic [3:0] tleft;
      logic [10:0] tsh;
      logic txd;
      logic rbusy;
      logic [15:0] rcnt;
      logic [3:0] ridx;
      logic [10:0] rsh;
      logic rx_valid;
      logic [7:0] rx_byte;
      logic rx_err;
   } sfpb_uart_t;

   typedef struct packed {
      sfpb_state_t state;
      sfpb_mode_t mode;
      logic bit_area;
      logic [`SFPB_ACC_W-1:0] acc;
      logic [7:0] drop;
      logic [7:0] op;
      logic [15:0] addr;
      logic [15:0] wdata;
      logic [2:0] idx;
      logic [7:0] csum;
      logic [7:0] rstat;
      logic [7:0] rhi;
      logic [23:0] tmo;
      logic [15:0] div;
      logic par_en;
      logic two_stop;
      logic rsp_valid;
      logic [`SFPB_ACC_W-1:0] rsp_acc;
      logic rsp_err;
      logic [7:0] rsp_code;
      logic [15:0] rsp_data;
      logic busy;
   } sfpb_st_t;

endpackage

/* sfpb_req_fifo.sv */
// request queue memory with registered read data
module sfpb_req_fifo #(
   parameter int W = 45,
   parameter int DEPTH = 4,
   parameter int AW = 2
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   // fill side
   input wire logic wr_valid,
   input wire logic [W-1:0] wr_data,
   output logic wr_ready,
   // drain side
   input wire logic rd_pop,
   output logic [W-1:0] rd_data,
   output logic rd_empty
);
   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
      logic [W-1:0] rd;
      logic rdy;
   } sfpb_fifo_t;

   sfpb_fifo_t q_r, q_nxt;
   logic push, pop;

   assign push = wr_valid && q_r.rdy;
   assign pop = rd_pop && (q_r.cnt != '0);
   assign wr_ready = q_r.rdy;
   assign rd_data = q_r.rd;
   assign rd_empty = (q_r.cnt == '0);

   always_comb begin
      q_nxt = q_r;
      if (push) begin
         q_nxt.mem[q_r.wp] = wr_data;
         q_nxt.wp = q_r.wp + 1'b1;
      end
      if (pop) begin
         q_nxt.rd = q_r.mem[q_r.rp];
         q_nxt.rp = q_r.rp + 1'b1;
      end
      q_nxt.cnt = q_r.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      // ready is registered so the port has no path from the requester
      q_nxt.rdy = (q_nxt.cnt != (AW+1)'(DEPTH));
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q_r <= '{rdy: 1'b1, default: '0};
      end else if (ce) begin
         q_r <= q_nxt;
      end
   end
endmodule // sfpb_req_fifo

/* sfpb_uart.sv */
// serial character engine: 8 data bits, optional even parity, 1 or 2 stops
`include "sfpb_params.svh"
module sfpb_uart (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   // controller side
   sfpb_char_if.uart ch,
   // line
   input wire logic rxd,
   output logic txd
);
   sfpb_pkg::sfpb_uart_t u_r, u_nxt;
   logic [3:0] nbits;
   logic tx_ready;

   assign nbits = 4'ha + {3'h0, ch.parity_en} + {3'h0, ch.two_stop};
   assign tx_ready = (u_r.tleft == 4'h0) && (u_r.tcnt == 16'h0000);
   assign ch.tx_ready = tx_ready;
   assign ch.rx_valid = u_r.rx_valid;
   assign ch.rx_byte = u_r.rx_byte;
   assign ch.rx_err = u_r.rx_err;
   assign txd = u_r.txd;

   always_comb begin
      logic [10:0] f;
      logic [10:0] sh;
      f = 11'h7ff;
      sh = u_r.rsh;
      u_nxt = u_r;
      u_nxt.rx_valid = 1'b0;
      // --------
      // transmit
      // --------
      if (ch.tx_valid && tx_ready) begin
         f[8:1] = ch.tx_byte;
         f[0] = 1'b0;
         if (ch.parity_en) begin
            f[9] = ^ch.tx_byte;
         end
         u_nxt.txd = 1'b0;
         u_nxt.tsh = {1'b1, f[10:1]};
         u_nxt.tleft = nbits - 4'h1;
         u_nxt.tcnt = ch.baud_div - 16'h0001;
      end else if (u_r.tcnt != 16'h0000) begin
         u_nxt.tcnt = u_r.tcnt - 16'h0001;
      end else if (u_r.tleft != 4'h0) begin
         u_nxt.txd = u_r.tsh[0];
         u_nxt.tsh = {1'b1, u_r.tsh[10:1]};
         u_nxt.tleft = u_r.tleft - 4'h1;
         u_nxt.tcnt = ch.baud_div - 16'h0001;
      end
      // --------
      // receive, sampled mid-bit
      // --------
      if (!u_r.rbusy) begin
         if (!rxd) begin
            u_nxt.rbusy = 1'b1;
            u_nxt.rcnt = {1'b0, ch.baud_div[15:1]};
            u_nxt.ridx = 4'h0;
         end
      end else if (u_r.rcnt != 16'h0000) begin
         u_nxt.rcnt = u_r.rcnt - 16'h0001;
      end else begin
         sh[u_r.ridx] = rxd;
         u_nxt.rsh = sh;
         u_nxt.rcnt = ch.baud_div - 16'h0001;
         u_nxt.ridx = u_r.ridx + 4'h1;
         if (u_r.ridx == nbits - 4'h1) begin
            u_nxt.rbusy = 1'b0;
            u_nxt.rx_valid = 1'b1;
            u_nxt.rx_byte = sh[8:1];
            // the last stop bit read low also flags a framing fault
            u_nxt.rx_err = sh[0] | (ch.parity_en & (sh[9] != ^sh[8:1])) | ~rxd;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         u_r <= '{txd: 1'b1, tsh: 11'h7ff, default: '0};
      end else if (ce) begin
         u_r <= u_nxt;
      end
   end
endmodule // sfpb_uart

/* test_serial_field_protocol_bridge.sv */
// self-checking bench for the serial field protocol bridge
module test_serial_field_protocol_bridge;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {
      logic [1:0] mode;
      logic wr, sil, ex, err;
      logic [7:0] drop, st, op, code;
      logic [15:0] rg;
   } sfpb_row_t;
   sfpb_row_t rows [8] = '{
      '{2'h0, 1'b0, 1'b0, 1'b1, 1'b0, 8'h01, 8'h06, 8'h01, 8'h00, 16'h0123},
      '{2'h0, 1'b1, 1'b0, 1'b1, 1'b0, 8'h2a, 8'h06, 8'h02, 8'h00, 16'h1fe0},
      '{2'h1, 1'b0, 1'b0, 1'b1, 1'b0, 8'h03, 8'h06, 8'h03, 8'h00, 16'h0400},
      '{2'h1, 1'b1, 1'b0, 1'b1, 1'b0, 8'hff, 8'h06, 8'h04, 8'h00, 16'hffff},
      '{2'h1, 1'b0, 1'b0, 1'b1, 1'b1, 8'h07, 8'h15, 8'h03, 8'h12, 16'h0010},
      '{2'h1, 1'b0, 1'b1, 1'b1, 1'b1, 8'h02, 8'h06, 8'h03, 8'h11, 16'h0001},
      '{2'h0, 1'b0, 1'b1, 1'b0, 1'b0, 8'h04, 8'h06, 8'h01, 8'h00, 16'h0002},
      '{2'h3, 1'b0, 1'b0, 1'b1, 1'b0, 8'h05, 8'h06, 8'h01, 8'h00, 16'h0777}};
   logic [15:0] bad_reg [4] = '{16'h0200, 16'h0379, 16'h0450, 16'h052f};
   logic ref_clk = 1'b0, clk_en = 1'b1;
   logic resetn;
   logic [1:0] mode = 2'h0;
   logic req_valid = 1'b0, req_write = 1'b0;
   logic [3:0] req_acc = 4'h0;
   logic [7:0] req_drop = 8'h00;
   logic [15:0] req_reg = 16'h0000, req_wdata = 16'h0000;
   logic req_ready, rsp_valid, rsp_err, busy, txd, rxd, par_bad, got;
   logic [3:0] rsp_acc;
   logic [7:0] rsp_code;
   logic [15:0] rsp_rdata;
   logic [55:0] fld_frame;
   logic [15:0] fld_lag = 16'h0010, fld_data = 16'h0000;
   logic fld_silent = 1'b0;
   logic [7:0] fld_status = 8'h06;
   int fail_count = 0, samples_checked = 0;
   sfpb_bridge #(.TMO_CYCLES(2000)) dut (.REF_CLK(ref_clk), .RESETN(resetn), .CLK_EN(clk_en),
      .MODE(mode), .CTRL_LARGE(1'b0), .BAUD_DIV(16'h0008), .REQ_VALID(req_valid),
      .REQ_READY(req_ready), .REQ_WRITE(req_write), .REQ_ACCESSOR(req_acc),
      .REQ_DROP(req_drop), .REQ_REG(req_reg), .REQ_WDATA(req_wdata), .RSP_VALID(rsp_valid),
      .RSP_ACCESSOR(rsp_acc), .RSP_ERROR(rsp_err), .RSP_CODE(rsp_code),
      .RSP_RDATA(rsp_rdata), .BUSY(busy), .RXD(rxd), .TXD(txd));
   sfpb_field_model u_fld (.clk(ref_clk), .txd(txd), .div(16'h0008), .par_en(1'b1),
      .lag(fld_lag), .silent(fld_silent), .status(fld_status), .data(fld_data), .rxd(rxd),
      .frame(fld_frame), .par_bad(par_bad));
   initial forever #10 ref_clk = ~ref_clk;
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic send_req(input logic [1:0] md, input logic wr, input logic [3:0] acc,
         input logic [7:0] dr, input logic [15:0] rg);
      @(negedge ref_clk);
      mode = md;
      req_write = wr;
      req_acc = acc;
      req_drop = dr;
      req_reg = rg;
      req_wdata = 16'hc3a5;
      req_valid = 1'b1;
      do @(posedge ref_clk); while (req_ready !== 1'b1);
      @(negedge ref_clk);
      req_valid = 1'b0;
   endtask
   task automatic wait_rsp(input int lim);
      got = 1'b0;
      for (int i = 0; i < lim && !got; i++) begin
         @(posedge ref_clk);
         #1 got = (rsp_valid === 1'b1);
      end
   endtask
   initial begin
      #1ms;
      fail_count++;
      $display("BAD watchdog expected done seen hang");
      stop_test();
   end
   initial begin
      resetn = 1'b1;
      #1 resetn = 1'b0;
      repeat (4) @(negedge ref_clk);
      check("reset outputs", 16'h0009, {12'h000, req_ready, rsp_valid, busy, txd});
      resetn = 1'b1;
      for (int r = 0; r < 8; r++) begin
         fld_status = rows[r].st;
         fld_silent = rows[r].sil;
         fld_data = 16'h5a00 | 16'(r);
         send_req(rows[r].mode, rows[r].wr, 4'h3, rows[r].drop, rows[r].rg);
         wait_rsp(4000);
         check("rsp seen", 16'(rows[r].ex), 16'(got));
         if (got) check("rsp error", 16'(rows[r].err), 16'(rsp_err));
         if (got) check("rsp accessor", 16'h0003, 16'(rsp_acc));
         if (got && rows[r].err) check("rsp code", 16'(rows[r].code), 16'(rsp_code));
         if (got && !rows[r].err && !rows[r].wr) check("rsp data", fld_data, rsp_rdata);
         check("frame op", 16'(rows[r].op), 16'(fld_frame[7:0]));
         check("frame drop", 16'(rows[r].drop), 16'(fld_frame[15:8]));
         check("frame reg", rows[r].rg, {fld_frame[23:16], fld_frame[31:24]});
         if (rows[r].wr) check("frame data", 16'hc3a5, {fld_frame[39:32], fld_frame[47:40]});
         if (rows[r].wr) check("frame sum", 16'(rows[r].op ^ rows[r].drop ^ rows[r].rg[15:8]
            ^ rows[r].rg[7:0] ^ 8'h66), 16'(fld_frame[55:48]));
         $display("row %0d done", r);
      end
      fld_silent = 1'b0;
      for (int b = 0; b < 4; b++) begin
         @(negedge ref_clk);
         send_req(2'h2, 1'b0, 4'h5, (b == 0) ? 8'h00 : 8'h01, bad_reg[b]);
         wait_rsp(10);
         check("ladder refuse", 16'h3135, {2'h0, got, rsp_err, rsp_code, rsp_acc});
      end
      $display("ladder refusals done");
      fld_lag = 16'd300;
      send_req(2'h1, 1'b0, 4'h1, 8'h09, 16'h0011);
      send_req(2'h1, 1'b0, 4'h2, 8'h0a, 16'h0022);
      for (int n = 1; n < 3; n++) begin
         wait_rsp(4000);
         check("queued accessor", 16'(n + 16), {11'h000, got, rsp_acc});
      end
      check("second drop", 16'h000a, 16'(fld_frame[15:8]));
      check("tx parity", 16'h0000, 16'(par_bad));
      $display("queued requests done");
      stop_test();
   end
endmodule // test_serial_field_protocol_bridge
